/* File: cbbd_core.sv */
// four-phase execute core for toggle, branch, call, clear, complement and skip
module cbbd_core
  import cbbd_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [INSTR_W-1:0] progData,
  input wire logic extendedEnable,
  input wire logic [DADDR_W-1:0] indexBase,
  input wire logic setupEn,
  input wire logic [7:0] setupWorking,
  input wire logic [3:0] setupBank,
  input wire logic [STATUS_W-1:0] setupStatus,
  output logic [PC_W-1:0] progAddr,
  output logic returnStackPush,
  output logic [PC_W-1:0] returnStackTop,
  output logic watchdogCounterClear,
  output logic [7:0] workingRegister,
  output logic [STATUS_W-1:0] statusRegister,
  output logic [3:0] bankSelectRegister,
  output logic [7:0] workingShadow,
  output logic [STATUS_W-1:0] statusShadow,
  output logic [3:0] bankSelectShadow,
  output logic timeoutFlag,
  output logic powerDownFlag,
  output logic dataWriteEn,
  output logic [DADDR_W-1:0] dataAddress,
  output logic [7:0] dataWriteData
);

  typedef struct packed {
    cbbd_phase_t phase;
    logic [PC_W-1:0] pc;
    logic [INSTR_W-1:0] instr;
    cbbd_op_t op;
    logic squash;
    logic skipMode;
    logic [DADDR_W-1:0] dataAddr;
    logic condMet;
    logic [7:0] result;
    logic ramWe;
    logic [7:0] working_register;
    logic [STATUS_W-1:0] status;
    logic [3:0] bank_select_register;
    logic [7:0] wShadow;
    logic [STATUS_W-1:0] stShadow;
    logic [3:0] bsrShadow;
    logic timeout;
    logic powerDown;
    logic stackPush;
    logic [PC_W-1:0] stackData;
    logic wdtClear;
  } cbbd_core_state_t;

  cbbd_core_state_t s_reg;
  cbbd_core_state_t s_next;
  logic [7:0] ramReadData;
  logic [7:0] diff;
  logic [PC_W-1:0] branchDest;

  function automatic cbbd_op_t decodeOp(input logic [15:0] w);
    if (matchOp(w, MASK_NIBBLE, OPV_BIT_TOGGLE)) return OP_TOGGLE;
    if (matchOp(w, MASK_BYTE, OPV_BRANCH_OVERFLOW)) return OP_BRANCH_OV;
    if (matchOp(w, MASK_BYTE, OPV_BRANCH_ZERO)) return OP_BRANCH_Z;
    if (matchOp(w, MASK_SEVEN, OPV_CALL)) return OP_CALL;
    if (matchOp(w, MASK_SEVEN, OPV_CLEAR_REG)) return OP_CLEAR_REG;
    if (matchOp(w, MASK_FULL, OPV_CLEAR_WATCHDOG)) return OP_CLEAR_WDT;
    if (matchOp(w, MASK_SIX, OPV_COMPLEMENT)) return OP_COMPLEMENT;
    if (matchOp(w, MASK_SEVEN, OPV_COMPARE_EQUAL)) return OP_COMPARE_EQ;
    if (matchOp(w, MASK_NIBBLE, OPV_BIT_TEST_SET)) return OP_BIT_TEST_SET;
    return OP_NONE;
  endfunction

  // words that drag a second word behind them
  function automatic logic isTwoWord(input logic [15:0] w);
    return matchOp(w, MASK_SEVEN, OPV_CALL) || matchOp(w, MASK_SEVEN, OPV_LONG_JUMP)
      || matchOp(w, MASK_NIBBLE, OPV_LONG_MOVE);
  endfunction

  // file address to data memory address
  function automatic logic [DADDR_W-1:0] fileAddress(input logic [15:0] w,
                                                     input logic [3:0] bank,
                                                     input logic ext,
                                                     input logic [DADDR_W-1:0] base);
    logic [7:0] f;
    f = w[7:0];
    if (!w[POS_ACCESS] && ext && (f <= INDEXED_LIMIT))
      return base + {ACCESS_LOW_BANK, f};
    if (!w[POS_ACCESS])
      return (f >= ACCESS_SPLIT) ? {ACCESS_HIGH_BANK, f} : {ACCESS_LOW_BANK, f};
    return {bank, f};
  endfunction

  cbbd_data_ram u_ram (
    .mclk(mclk),
    .writeEn(s_reg.ramWe),
    .writeAddr(s_reg.dataAddr),
    .writeData(s_reg.result),
    .readAddr(s_reg.dataAddr),
    .readData(ramReadData)
  );

  // unsigned subtraction for the compare; zero difference means equal
  assign diff = ramReadData - s_reg.working_register;
  // counter already points past this word, so it is the incremented base
  assign branchDest = s_reg.pc + {{12{s_reg.instr[7]}}, s_reg.instr[7:0], 1'b0};

  // next state: one phase per clock, four clocks per instruction cycle
  always_comb
  begin
    s_next = s_reg;
    s_next.stackPush = 1'b0;
    s_next.wdtClear = 1'b0;
    s_next.ramWe = 1'b0;
    if (setupEn)
    begin
      s_next.working_register = setupWorking;
      s_next.bank_select_register = setupBank;
      s_next.status = setupStatus;
    end
    unique case (s_reg.phase)
      PH_DECODE:
      begin
        s_next.phase = PH_READ;
        // a squashed word runs as a no-operation
        s_next.op = s_reg.squash ? OP_NONE : decodeOp(s_reg.instr);
        s_next.dataAddr = fileAddress(s_reg.instr, s_reg.bank_select_register, extendedEnable, indexBase);
      end
      PH_READ:
      begin
        s_next.phase = PH_PROCESS;
        if (s_reg.op == OP_CALL)
        begin
          s_next.stackPush = 1'b1;
          s_next.stackData = s_reg.pc + PC_STEP;
        end
      end
      PH_PROCESS:
      begin
        s_next.phase = PH_WRITE;
        s_next.condMet = 1'b0;
        s_next.result = ramReadData;
        unique case (s_reg.op)
          OP_TOGGLE:
          begin
            s_next.result = ramReadData ^ bitMask(s_reg.instr[POS_BIT_LSB +: 3]);
            s_next.ramWe = 1'b1;
          end
          OP_BRANCH_OV: s_next.condMet = s_reg.status[ST_OV];
          OP_BRANCH_Z: s_next.condMet = s_reg.status[ST_Z];
          OP_CLEAR_REG:
          begin
            s_next.result = CLEAR_VALUE;
            s_next.ramWe = 1'b1;
          end
          OP_CLEAR_WDT:
          begin
            s_next.wdtClear = 1'b1;
            s_next.timeout = 1'b1;
            s_next.powerDown = 1'b1;
          end
          OP_COMPLEMENT:
          begin
            s_next.result = ~ramReadData;
            s_next.ramWe = s_reg.instr[POS_DEST];
          end
          OP_COMPARE_EQ: s_next.condMet = (diff == CLEAR_VALUE);
          OP_BIT_TEST_SET: s_next.condMet = ramReadData[s_reg.instr[POS_BIT_LSB +: 3]];
          default: s_next.condMet = 1'b0;
        endcase
      end
      PH_WRITE:
      begin
        s_next.phase = PH_DECODE;
        // overlapped fetch: the word at the counter becomes the next instruction
        s_next.instr = progData;
        s_next.pc = s_reg.pc + PC_STEP;
        s_next.squash = 1'b0;
        s_next.skipMode = 1'b0;
        // a skipped two-word instruction costs one more dead cycle
        if (s_reg.squash && s_reg.skipMode && isTwoWord(s_reg.instr))
        begin
          s_next.squash = 1'b1;
        end
        unique case (s_reg.op)
          OP_BRANCH_OV, OP_BRANCH_Z:
          begin
            if (s_reg.condMet)
            begin
              s_next.pc = branchDest;
              s_next.squash = 1'b1;
            end
          end
          OP_CALL:
          begin
            // second word comes straight off the fetch port and is consumed here
            s_next.pc = {progData[POS_HIGH_ADDR_MSB:0], s_reg.instr[7:0], 1'b0};
            s_next.squash = 1'b1;
            if (s_reg.instr[POS_FAST])
            begin
              s_next.wShadow = s_reg.working_register;
              s_next.stShadow = s_reg.status;
              s_next.bsrShadow = s_reg.bank_select_register;
            end
          end
          OP_CLEAR_REG: s_next.status[ST_Z] = 1'b1;
          OP_COMPLEMENT:
          begin
            if (!s_reg.instr[POS_DEST])
            begin
              s_next.working_register = s_reg.result;
            end
            s_next.status[ST_N] = s_reg.result[7];
            s_next.status[ST_Z] = (s_reg.result == CLEAR_VALUE);
          end
          OP_COMPARE_EQ, OP_BIT_TEST_SET:
          begin
            if (s_reg.condMet)
            begin
              s_next.squash = 1'b1;
              s_next.skipMode = 1'b1;
            end
          end
          default: s_next.squash = s_next.squash;
        endcase
      end
      default: s_next.phase = PH_DECODE;
    endcase
  end

  // state register; first cycle after reset is a dead fetch cycle
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '{phase: PH_DECODE, pc: PC_RESET, instr: INSTR_NOP, op: OP_NONE, squash: 1'b1,
                 skipMode: 1'b0, dataAddr: DADDR_RESET, condMet: 1'b0, result: CLEAR_VALUE,
                 ramWe: 1'b0, working_register: W_RESET, status: STATUS_RESET, bank_select_register: BSR_RESET,
                 wShadow: W_RESET, stShadow: STATUS_RESET, bsrShadow: BSR_RESET,
                 timeout: 1'b0, powerDown: 1'b0, stackPush: 1'b0, stackData: PC_RESET,
                 wdtClear: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs are plain state fields
  assign progAddr = s_reg.pc;
  assign returnStackPush = s_reg.stackPush;
  assign returnStackTop = s_reg.stackData;
  assign watchdogCounterClear = s_reg.wdtClear;
  assign workingRegister = s_reg.working_register;
  assign statusRegister = s_reg.status;
  assign bankSelectRegister = s_reg.bank_select_register;
  assign workingShadow = s_reg.wShadow;
  assign statusShadow = s_reg.stShadow;
  assign bankSelectShadow = s_reg.bsrShadow;
  assign timeoutFlag = s_reg.timeout;
  assign powerDownFlag = s_reg.powerDown;
  assign dataWriteEn = s_reg.ramWe;
  assign dataAddress = s_reg.dataAddr;
  assign dataWriteData = s_reg.result;

  // checks on phase sequencing and per-instruction effects
  a_phase_order: assert property (@(posedge mclk) disable iff (!arst_n)
    s_reg.phase == PH_DECODE |=> s_reg.phase == PH_READ ##1 s_reg.phase == PH_PROCESS
      ##1 s_reg.phase == PH_WRITE)
    else $error("phase sequence broken");

  a_toggle_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && s_reg.op == OP_TOGGLE) |->
      s_reg.ramWe && s_reg.result == (ramReadData ^ bitMask(s_reg.instr[POS_BIT_LSB +: 3])))
    else $error("toggle wrote wrong byte");

  a_bank_pick: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_DECODE && s_reg.instr[POS_ACCESS]) |=>
      s_reg.dataAddr == {$past(s_reg.bank_select_register), $past(s_reg.instr[7:0])})
    else $error("banked address wrong");

  a_indexed_mode: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_DECODE && !s_reg.instr[POS_ACCESS] && extendedEnable
      && s_reg.instr[7:0] <= INDEXED_LIMIT) |=>
      s_reg.dataAddr == $past(indexBase) + {ACCESS_LOW_BANK, $past(s_reg.instr[7:0])})
    else $error("indexed address wrong");

  a_branch_status: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && (s_reg.op == OP_BRANCH_OV || s_reg.op == OP_BRANCH_Z)
      && !setupEn) |=> $stable(s_reg.status))
    else $error("branch changed status");

  a_branch_taken: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && s_reg.op == OP_BRANCH_Z && s_reg.condMet) |=>
      progAddr == $past(branchDest) && s_reg.squash ##4 !s_reg.squash)
    else $error("taken branch target or flush wrong");

  a_call_push: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_READ && s_reg.op == OP_CALL) |=>
      returnStackPush && returnStackTop == $past(s_reg.pc) + PC_STEP ##1 !returnStackPush)
    else $error("call push wrong");

  a_call_target: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && s_reg.op == OP_CALL) |=>
      progAddr == {$past(progData[POS_HIGH_ADDR_MSB:0]), $past(s_reg.instr[7:0]), 1'b0}
      && s_reg.squash)
    else $error("call target wrong");

  a_call_shadow: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && s_reg.op == OP_CALL) |=>
      (workingShadow == ($past(s_reg.instr[POS_FAST]) ? $past(s_reg.working_register)
        : $past(s_reg.wShadow))) && (bankSelectShadow == ($past(s_reg.instr[POS_FAST])
        ? $past(s_reg.bank_select_register) : $past(s_reg.bsrShadow))))
    else $error("shadow copy wrong");

  a_clear_reg: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && s_reg.op == OP_CLEAR_REG) |->
      s_reg.ramWe && s_reg.result == CLEAR_VALUE ##1 s_reg.status[ST_Z])
    else $error("clear register wrong");

  a_watchdog_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_PROCESS && s_reg.op == OP_CLEAR_WDT) |=>
      watchdogCounterClear && timeoutFlag && powerDownFlag ##1 !watchdogCounterClear)
    else $error("watchdog clear wrong");

  a_complement_dest: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && s_reg.op == OP_COMPLEMENT && !s_reg.instr[POS_DEST]
      && !setupEn) |=> workingRegister == ~$past(ramReadData)
      && statusRegister[ST_N] == workingRegister[7])
    else $error("complement result wrong");

  a_skip_equal: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_PROCESS && s_reg.op == OP_COMPARE_EQ && ramReadData == s_reg.working_register)
      |=> s_reg.condMet ##1 s_reg.squash && s_reg.skipMode)
    else $error("equal compare did not skip");

  a_skip_two_word: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_reg.phase == PH_WRITE && s_reg.squash && s_reg.skipMode && isTwoWord(s_reg.instr))
      |=> s_reg.squash && !s_reg.skipMode ##4 !s_reg.squash)
    else $error("two-word skip length wrong");

endmodule // cbbd_core

/* File: cbbd_data_ram.sv */
// byte-wide data memory with registered read data
module cbbd_data_ram
  import cbbd_pkg::*;
(
  input wire logic mclk,
  input wire logic writeEn,
  input wire logic [DADDR_W-1:0] writeAddr,
  input wire logic [7:0] writeData,
  input wire logic [DADDR_W-1:0] readAddr,
  output logic [7:0] readData
);

  logic [7:0] mem [DATA_DEPTH];

  // no reset on the array: contents are undefined until software writes them
  always_ff @(posedge mclk)
  begin
    if (writeEn)
    begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end

endmodule // cbbd_data_ram

/* File: cbbd_pkg.sv */
// constants, types and shared decode helpers for the bit/branch/call decoder
package cbbd_pkg;

  localparam int PC_W = 21;
  localparam int INSTR_W = 16;
  localparam int DADDR_W = 12;
  localparam int DATA_DEPTH = 4096;
  localparam int STATUS_W = 5;

  // opcode masks and match values
  localparam logic [15:0] MASK_NIBBLE = 16'hF000;
  localparam logic [15:0] MASK_BYTE = 16'hFF00;
  localparam logic [15:0] MASK_SEVEN = 16'hFE00;
  localparam logic [15:0] MASK_SIX = 16'hFC00;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] OPV_BIT_TOGGLE = 16'h7000;
  localparam logic [15:0] OPV_BRANCH_OVERFLOW = 16'hE400;
  localparam logic [15:0] OPV_BRANCH_ZERO = 16'hE000;
  localparam logic [15:0] OPV_CALL = 16'hEC00;
  localparam logic [15:0] OPV_CLEAR_REG = 16'h6A00;
  localparam logic [15:0] OPV_CLEAR_WATCHDOG = 16'h0004;
  localparam logic [15:0] OPV_COMPLEMENT = 16'h1C00;
  localparam logic [15:0] OPV_COMPARE_EQUAL = 16'h6200;
  localparam logic [15:0] OPV_BIT_TEST_SET = 16'hA000;
  localparam logic [15:0] OPV_LONG_JUMP = 16'hEE00;
  localparam logic [15:0] OPV_LONG_MOVE = 16'hC000;
  localparam logic [15:0] INSTR_NOP = 16'h0000;

  // field positions inside an instruction word
  localparam int POS_ACCESS = 8;
  localparam int POS_DEST = 9;
  localparam int POS_FAST = 8;
  localparam int POS_BIT_LSB = 9;
  localparam int POS_HIGH_ADDR_MSB = 11;

  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;

  // addressing limits and values
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;

  // counter step and reset values
  localparam logic [20:0] PC_STEP = 21'h0_0002;
  localparam logic [20:0] PC_RESET = 21'h0_0000;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [3:0] BSR_RESET = 4'h0;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [11:0] DADDR_RESET = 12'h000;

  typedef enum logic [3:0] {
    PH_DECODE = 4'b0001,
    PH_READ = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE = 4'b1000
  } cbbd_phase_t;

  typedef enum logic [9:0] {
    OP_NONE = 10'b00_0000_0001,
    OP_TOGGLE = 10'b00_0000_0010,
    OP_BRANCH_OV = 10'b00_0000_0100,
    OP_BRANCH_Z = 10'b00_0000_1000,
    OP_CALL = 10'b00_0001_0000,
    OP_CLEAR_REG = 10'b00_0010_0000,
    OP_CLEAR_WDT = 10'b00_0100_0000,
    OP_COMPLEMENT = 10'b00_1000_0000,
    OP_COMPARE_EQ = 10'b01_0000_0000,
    OP_BIT_TEST_SET = 10'b10_0000_0000
  } cbbd_op_t;

  function automatic logic matchOp(input logic [15:0] word, input logic [15:0] mask,
                                   input logic [15:0] value);
    return (word & mask) == value;
  endfunction

  function automatic logic [7:0] bitMask(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction

endpackage

/* File: cpu_bit_branch_call_decode_bench.sv */
// self-checking random bench for the bit, branch and call decode core
`define CBBD_CHECK(g, e) \
  begin \
    checksDone++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end

module cpu_bit_branch_call_decode_bench
  import cbbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [INSTR_W-1:0] progData = INSTR_NOP;
  logic extendedEnable = 1'b0;
  logic [DADDR_W-1:0] indexBase = 12'h000;
  logic setupEn = 1'b0;
  logic [7:0] setupWorking = 8'h00;
  logic [3:0] setupBank = 4'h0;
  logic [STATUS_W-1:0] setupStatus = 5'h00;
  logic [PC_W-1:0] progAddr, returnStackTop;
  logic returnStackPush, watchdogCounterClear, timeoutFlag, powerDownFlag, dataWriteEn;
  logic [7:0] workingRegister, workingShadow, dataWriteData;
  logic [STATUS_W-1:0] statusRegister, statusShadow;
  logic [3:0] bankSelectRegister, bankSelectShadow;
  logic [DADDR_W-1:0] dataAddress;
  // bench state: counters, random source and the expected register image
  int miscompares = 0;
  int checksDone = 0;
  logic [15:0] rngState = 16'h14B1;
  logic [15:0] r, r2, r3;
  logic [20:0] pcExp, jumpTgt, callAddr;
  logic jump, capPush, capWe, capWdc, a, eq, taken;
  logic [11:0] capAddr, addr;
  logic [7:0] capData, f, mask, wExp, wsExp;
  logic [3:0] bankExp, bsExp;
  logic [4:0] stExp, ssExp;
  logic [2:0] b;

  cbbd_core cbbd_core_inst (
    .mclk(mclk), .arst_n(arst_n), .progData(progData), .extendedEnable(extendedEnable),
    .indexBase(indexBase), .setupEn(setupEn), .setupWorking(setupWorking),
    .setupBank(setupBank), .setupStatus(setupStatus), .progAddr(progAddr),
    .returnStackPush(returnStackPush), .returnStackTop(returnStackTop),
    .watchdogCounterClear(watchdogCounterClear), .workingRegister(workingRegister),
    .statusRegister(statusRegister), .bankSelectRegister(bankSelectRegister),
    .workingShadow(workingShadow), .statusShadow(statusShadow),
    .bankSelectShadow(bankSelectShadow), .timeoutFlag(timeoutFlag),
    .powerDownFlag(powerDownFlag), .dataWriteEn(dataWriteEn), .dataAddress(dataAddress),
    .dataWriteData(dataWriteData)
  );

  // 25 MHz core clock
  always #20 mclk = ~mclk;

  // sixteen-bit shift register, seeded so every run repeats
  function automatic logic [15:0] rnd();
    rngState = {rngState[14:0], rngState[15] ^ rngState[13] ^ rngState[12] ^ rngState[10]};
    return rngState;
  endfunction

  // where an operand byte should land, worked out independently of the core
  function automatic logic [11:0] resolveAddr(input logic [7:0] fa, input logic ab,
                                              input logic [3:0] bk, input logic ext,
                                              input logic [11:0] base);
    if (ab)
      return {bk, fa};
    if (ext && fa <= 8'h5F)
      return base + {4'h0, fa};
    return {(fa[7] ? 4'hF : 4'h0), fa};
  endfunction

  // one instruction cycle: present a word, sample the executing one, check the fetch address
  task automatic issue(input logic [15:0] word);
    progData = word;
    @(posedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    capPush = returnStackPush;
    @(posedge mclk);
    @(negedge mclk);
    capWe = dataWriteEn;
    capAddr = dataAddress;
    capData = dataWriteData;
    capWdc = watchdogCounterClear;
    @(posedge mclk);
    @(negedge mclk);
    pcExp = jump ? jumpTgt : pcExp + PC_STEP;
    jump = 1'b0;
    `CBBD_CHECK(progAddr, pcExp)
  endtask

  task automatic regs();
    `CBBD_CHECK(workingRegister, wExp)
    `CBBD_CHECK(statusRegister, stExp)
    `CBBD_CHECK(bankSelectRegister, bankExp)
    `CBBD_CHECK(workingShadow, wsExp)
    `CBBD_CHECK(statusShadow, ssExp)
    `CBBD_CHECK(bankSelectShadow, bsExp)
  endtask

  // setup load rides on a no-op cycle so no instruction write competes with it
  task automatic setup(input logic [7:0] w, input logic [3:0] bk, input logic [4:0] st);
    setupEn = 1'b1;
    setupWorking = w;
    setupBank = bk;
    setupStatus = st;
    issue(INSTR_NOP);
    setupEn = 1'b0;
    wExp = w;
    bankExp = bk;
    stExp = st;
    regs();
  endtask

  task automatic chkWrite(input logic [11:0] ad, input logic [7:0] dt);
    `CBBD_CHECK(capWe, 1'b1)
    `CBBD_CHECK(capAddr, ad)
    `CBBD_CHECK(capData, dt)
  endtask

  task automatic testDone();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog: the tests need about 2200 clocks, so 20000 means a hang
  initial
  begin
    #(40 * 20000);
    miscompares++;
    testDone();
  end

  // main sequence
  initial
  begin
    jump = 1'b0;
    pcExp = PC_RESET;
    {wExp, wsExp, bankExp, bsExp, stExp, ssExp} = 34'h0_0000_0000;
    repeat (16) @(negedge mclk);
    `CBBD_CHECK(progAddr, PC_RESET)
    arst_n = 1'b1;
    issue(INSTR_NOP);
    `CBBD_CHECK(timeoutFlag, 1'b0)
    issue(OPV_CLEAR_WATCHDOG);
    issue(INSTR_NOP);
    `CBBD_CHECK(capWdc, 1'b1)
    `CBBD_CHECK(timeoutFlag, 1'b1)
    `CBBD_CHECK(powerDownFlag, 1'b1)
    regs();
    $display("test watchdog done");
    for (int i = 0; i < 24; i++)
    begin
      r = rnd();
      r2 = rnd();
      f = r[7:0];
      a = r[8];
      b = r[11:9];
      extendedEnable = r[12];
      indexBase = r2[11:0];
      // first passes pin the indexed-offset boundary and the access bank split
      if (i < 3)
      begin
        a = 1'b0;
        extendedEnable = 1'b1;
        f = (i == 0) ? 8'h5F : ((i == 1) ? 8'h60 : 8'h80);
      end
      r3 = rnd();
      setup(r3[7:0], r3[11:8], r2[15:11]);
      addr = resolveAddr(f, a, bankExp, extendedEnable, indexBase);
      mask = 8'h01 << b;
      issue(OPV_CLEAR_REG | {7'h00, a, f});
      issue(OPV_BIT_TOGGLE | {4'h0, b, a, f});
      stExp[ST_Z] = 1'b1;
      chkWrite(addr, CLEAR_VALUE);
      regs();
      issue(OPV_COMPLEMENT | {6'h00, 1'b1, a, f});
      chkWrite(addr, mask);
      regs();
      issue(OPV_COMPLEMENT | {7'h00, a, f});
      chkWrite(addr, ~mask);
      stExp[ST_N] = ~mask[7];
      stExp[ST_Z] = 1'b0;
      regs();
      issue(INSTR_NOP);
      `CBBD_CHECK(capWe, 1'b0)
      wExp = mask;
      stExp[ST_N] = mask[7];
      regs();
      // compare against the stored byte, then skip one word or a two-word call
      eq = r3[12];
      setup(eq ? ~mask : ~mask ^ {r2[6:0], 1'b1}, bankExp, stExp);
      issue(OPV_COMPARE_EQUAL | {7'h00, a, f});
      if (r3[13])
      begin
        issue(OPV_CALL | {8'h00, r2[7:0]});
        jump = !eq;
        jumpTgt = {r[11:0], r2[7:0], 1'b0};
        issue(16'hF000 | {4'h0, r[11:0]});
        `CBBD_CHECK(capPush, !eq)
        issue(OPV_CLEAR_WATCHDOG);
        issue(INSTR_NOP);
        `CBBD_CHECK(capWdc, 1'b1)
      end
      else
      begin
        issue(OPV_CLEAR_WATCHDOG);
        issue(INSTR_NOP);
        `CBBD_CHECK(capWdc, !eq)
      end
      // bit test on the stored byte: only bit b reads zero, so any other bit skips
      issue(OPV_BIT_TEST_SET | {4'h0, r3[15:13], a, f});
      issue(OPV_CLEAR_WATCHDOG);
      issue(INSTR_NOP);
      `CBBD_CHECK(capWdc, r3[15:13] == b)
      regs();
      // conditional branch on random flags; the word behind a taken branch is dropped
      r = rnd();
      setup(wExp, bankExp, r[15:11]);
      taken = r[8] ? stExp[ST_OV] : stExp[ST_Z];
      issue((r[8] ? OPV_BRANCH_OVERFLOW : OPV_BRANCH_ZERO) | {8'h00, r[7:0]});
      jump = taken;
      jumpTgt = pcExp + {{12{r[7]}}, r[7:0], 1'b0};
      issue(OPV_CLEAR_WATCHDOG);
      issue(INSTR_NOP);
      `CBBD_CHECK(capWdc, !taken)
      regs();
      // two-word call with a random fast-save bit
      r = rnd();
      r2 = rnd();
      r3 = rnd();
      setup(r[7:0], r[11:8], r2[15:11]);
      callAddr = pcExp;
      issue(OPV_CALL | {7'h00, r[12], r2[7:0]});
      jump = 1'b1;
      jumpTgt = {r3[11:0], r2[7:0], 1'b0};
      issue(16'hF000 | {4'h0, r3[11:0]});
      `CBBD_CHECK(capPush, 1'b1)
      `CBBD_CHECK(returnStackTop, callAddr + 21'h0_0004)
      if (r[12])
      begin
        wsExp = wExp;
        ssExp = stExp;
        bsExp = bankExp;
      end
      issue(INSTR_NOP);
      regs();
    end
    $display("test random sequences done");
    testDone();
  end
endmodule // cpu_bit_branch_call_decode_bench
